// ### sarrd_pkg.sv
`default_nettype none
package sarrd_pkg;
  localparam int RES_DEFAULT       = 16;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int CONV_TIME_NS      = 710;
  // Longest time: round down
  localparam int CONV_MAX_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
  // Two synchroniser stages plus the edge detector
  localparam int SYNC_LAT          = 3;
  localparam int CONV_CYC_DEFAULT  = CONV_MAX_CYC - SYNC_LAT;
  localparam int CAL_TIME_MS       = 500;
  localparam int CAL_CYC_DEFAULT   = CAL_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Least times: round up
  localparam int QUIET_TIME_NS     = 10;
  localparam int QUIET_CYC         = (QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_TIME_NS        = 10;
  localparam int EN_CYC            = (EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECAL_PULSES      = 1024;
  localparam int SCLK_HALF_DEFAULT = 8;
  localparam int CAL_POLL_DELAY    = 16;

  typedef enum logic [1:0] {
    DEV_CAL  = 2'h0,
    DEV_ACQ  = 2'h1,
    DEV_CONV = 2'h3
  } sarrd_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE    = 3'h0,
    H_CONV    = 3'h1,
    H_EN      = 3'h3,
    H_SHIFT   = 3'h2,
    H_QUIET   = 3'h6,
    H_RECAL   = 3'h7,
    H_WAITCAL = 3'h5
  } sarrd_host_state_t;
endpackage
`default_nettype wire

// ### sarrd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sarrd_link_if;
  logic convStartSelect;
  logic sclk;
  logic sdi;
  logic sdoOut;
  logic sdoOe;
  logic sdo;

  // External pull-up on SDO: a released line reads high
  assign sdo = sdoOe ? sdoOut : 1'h1;

  modport dev (
    input  convStartSelect,
    input  sclk,
    input  sdi,
    output sdoOut,
    output sdoOe
  );

  modport host (
    output convStartSelect,
    output sclk,
    output sdi,
    input  sdo
  );
endinterface
`default_nettype wire

// ### sarrd_device.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Track input in acquisition until start edge
// - Start edge freezes sample, starts conversion
// - Conversion runs to end regardless of pin
// - Conversion ends within 710 ns
// - Result on SDO once host lowers pin
// - MSB first, SDO changes on SCLK fall
// - Next acquisition runs during readout
// - Host leaves quiet time before next start
// - Sample rate is one over acquisition plus conversion
// - Host SCLK fits N bits in acquisition
// - Two's complement, sign bit first
// - Zero, negative and positive full scale codes
// - Saturate beyond full scale
// - One pin is select and conversion trigger
// - Host holds SDI high
// - Release SDO after last bit or pin high
// - 1024 SCLK pulses in acquisition recalibrate
// - SDO driven low during calibration, then released
// - Calibration lasts about 500 ms
// - Host may capture on either SCLK edge
// - Calibrate at power-up, then acquire
module sarrd_device #(
  parameter int RES      = sarrd_pkg::RES_DEFAULT,
  parameter int CONV_CYC = sarrd_pkg::CONV_CYC_DEFAULT,
  parameter int CAL_CYC  = sarrd_pkg::CAL_CYC_DEFAULT
) (
  // Internal clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  // Pins towards the host
  sarrd_link_if.dev                  link,
  // Held analog value in LSBs, two bits wider than the code to show overrange
  input  wire logic signed [RES+1:0] analogIn,
  // Phase status
  output logic                       tracking,
  output logic                       converting,
  output logic                       calibrating
);

  localparam int FC_W  = $clog2(RES + 1);
  localparam int PC_W  = $clog2(sarrd_pkg::RECAL_PULSES + 1);
  // One counter times both phases, so it must hold the longer of the two
  localparam int CNT_W = $clog2((CAL_CYC > CONV_CYC ? CAL_CYC : CONV_CYC) + 1);
  localparam logic [FC_W-1:0]  LAST_FALL   = FC_W'(RES);
  localparam logic [PC_W-1:0]  LAST_PULSE  = PC_W'(sarrd_pkg::RECAL_PULSES - 1);
  localparam logic [CNT_W-1:0] CONV_END    = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] CAL_END     = CNT_W'(CAL_CYC - 1);
  localparam logic signed [RES+1:0] CODE_MAX = $signed({3'h0, {(RES - 1){1'h1}}});
  localparam logic signed [RES+1:0] CODE_MIN = $signed({3'h7, {(RES - 1){1'h0}}});

  generate
    if (RES != 16 && RES != 14 && RES != 12) begin : g_bad_res
      $error("RES must be 16, 14 or 12");
    end
    if (CONV_CYC < 1 || CONV_CYC > sarrd_pkg::CONV_MAX_CYC - sarrd_pkg::SYNC_LAT) begin : g_bad_conv
      $error("CONV_CYC out of range");
    end
    if (CAL_CYC < 1) begin : g_bad_cal
      $error("CAL_CYC must be positive");
    end
  endgenerate

  // Link domain: counters restart with every frame, because the pin going high
  // holds them in reset; SCLK may stand still between frames.
  logic            linkRst_n;
  logic [FC_W-1:0] fallCnt;
  logic [PC_W-1:0] pulseCnt;
  logic            recalToggle;

  assign linkRst_n = arst_n & ~link.convStartSelect;

  always_ff @(negedge link.sclk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      fallCnt <= '0;
    end else if (fallCnt != LAST_FALL) begin
      fallCnt <= fallCnt + 1'h1;
    end
  end

  always_ff @(posedge link.sclk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      pulseCnt <= '0;
    end else if (pulseCnt <= LAST_PULSE) begin
      pulseCnt <= pulseCnt + 1'h1;
    end
  end

  // Toggle survives the frame's end so the event is not lost
  always_ff @(posedge link.sclk or negedge arst_n) begin
    if (!arst_n) begin
      recalToggle <= 1'h0;
    end else if (linkRst_n && pulseCnt == LAST_PULSE) begin
      recalToggle <= ~recalToggle;
    end
  end

  // Internal domain synchronisers
  logic csSync1;
  logic csSync2;
  logic csPrev;
  logic recSync1;
  logic recSync2;
  logic recPrev;
  logic csRise;
  logic recalEvent;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      csSync1  <= 1'h0;
      csSync2  <= 1'h0;
      csPrev   <= 1'h0;
      recSync1 <= 1'h0;
      recSync2 <= 1'h0;
      recPrev  <= 1'h0;
    end else begin
      csSync1  <= link.convStartSelect;
      csSync2  <= csSync1;
      csPrev   <= csSync2;
      recSync1 <= recalToggle;
      recSync2 <= recSync1;
      recPrev  <= recSync2;
    end
  end

  assign csRise     = csSync2 & ~csPrev;
  assign recalEvent = recSync2 ^ recPrev;

  // Phase sequencer
  sarrd_pkg::sarrd_dev_state_t state;
  sarrd_pkg::sarrd_dev_state_t next_state;
  logic [CNT_W-1:0]            cnt;

  always_comb begin
    next_state = state;
    case (state)
      sarrd_pkg::DEV_CAL: begin
        if (cnt == CAL_END) begin
          next_state = sarrd_pkg::DEV_ACQ;
        end
      end
      sarrd_pkg::DEV_ACQ: begin
        if (recalEvent) begin
          next_state = sarrd_pkg::DEV_CAL;
        end else if (csRise) begin
          next_state = sarrd_pkg::DEV_CONV;
        end
      end
      sarrd_pkg::DEV_CONV: begin
        // The pin is not looked at here
        if (cnt == CONV_END) begin
          next_state = sarrd_pkg::DEV_ACQ;
        end
      end
      default: begin
        next_state = sarrd_pkg::DEV_CAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sarrd_pkg::DEV_CAL;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (next_state != state) begin
      cnt <= '0;
    end else if (state != sarrd_pkg::DEV_ACQ) begin
      cnt <= cnt + 1'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tracking    <= 1'h0;
      converting  <= 1'h0;
      calibrating <= 1'h1;
    end else begin
      tracking    <= next_state == sarrd_pkg::DEV_ACQ;
      converting  <= next_state == sarrd_pkg::DEV_CONV;
      calibrating <= next_state == sarrd_pkg::DEV_CAL;
    end
  end

  // Sample hold and result
  logic signed [RES+1:0] heldIn;
  logic [RES-1:0]        result;
  logic                  resultValid;

  function automatic logic [RES-1:0] saturate(input logic signed [RES+1:0] v);
    if (v > CODE_MAX) begin
      saturate = CODE_MAX[RES-1:0];
    end else if (v < CODE_MIN) begin
      saturate = CODE_MIN[RES-1:0];
    end else begin
      saturate = v[RES-1:0];
    end
  endfunction

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      heldIn      <= '0;
      result      <= '0;
      resultValid <= 1'h0;
    end else if (state == sarrd_pkg::DEV_ACQ && next_state == sarrd_pkg::DEV_CONV) begin
      heldIn      <= analogIn;
      resultValid <= 1'h0;
    end else if (state == sarrd_pkg::DEV_CONV && next_state == sarrd_pkg::DEV_ACQ) begin
      result      <= saturate(heldIn);
      resultValid <= 1'h1;
    end else if (next_state == sarrd_pkg::DEV_CAL) begin
      resultValid <= 1'h0;
    end
  end

  // Result is static while the pin is low, since it changes only as a conversion ends, with the pin still high; valid also clears
  // when a recalibration starts, in the cycle calibrating rises; the link side reads them without a synchroniser.
  logic [RES-1:0] shifted;

  assign shifted = result << fallCnt;

  always_comb begin
    if (calibrating) begin
      link.sdoOut = 1'h0;
      link.sdoOe  = 1'h1;
    end else begin
      link.sdoOut = shifted[RES-1];
      link.sdoOe  = resultValid & ~link.convStartSelect & (fallCnt != LAST_FALL);
    end
  end

endmodule
`default_nettype wire

// ### sarrd_host.sv
`timescale 1ns/1ps
`default_nettype none
module sarrd_host #(
  parameter int RES       = sarrd_pkg::RES_DEFAULT,
  parameter int SCLK_HALF = sarrd_pkg::SCLK_HALF_DEFAULT,
  parameter int CONV_WAIT = sarrd_pkg::CONV_MAX_CYC + 1
) (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  // Pins towards the converter
  sarrd_link_if.host          link,
  // User requests
  input  wire logic           sampleReq,
  input  wire logic           recalReq,
  // User answers
  output logic                ready,
  output logic [RES-1:0]      sampleData,
  output logic                sampleValid,
  output logic                calDone
);

  localparam int CNT_W = 16;
  localparam int BIT_W = $clog2(sarrd_pkg::RECAL_PULSES + 1);
  localparam logic [CNT_W-1:0] HALF_END  = CNT_W'(SCLK_HALF - 1);
  localparam logic [CNT_W-1:0] CONV_END  = CNT_W'(CONV_WAIT - 1);
  // Two extra cycles cover the SDO synchroniser
  localparam logic [CNT_W-1:0] EN_END    = CNT_W'(sarrd_pkg::EN_CYC + 1);
  localparam logic [CNT_W-1:0] QUIET_END = CNT_W'(sarrd_pkg::QUIET_CYC - 1);
  localparam logic [CNT_W-1:0] POLL_END  = CNT_W'(sarrd_pkg::CAL_POLL_DELAY - 1);
  localparam logic [BIT_W-1:0] DATA_BITS = BIT_W'(RES);
  localparam logic [BIT_W-1:0] CAL_BITS  = BIT_W'(sarrd_pkg::RECAL_PULSES);

  generate
    if (RES != 16 && RES != 14 && RES != 12) begin : g_bad_res
      $error("RES must be 16, 14 or 12");
    end
    if (SCLK_HALF < 4 || SCLK_HALF > 60000) begin : g_bad_half
      $error("SCLK_HALF must cover the SDO synchroniser");
    end
    if (CONV_WAIT <= sarrd_pkg::CONV_MAX_CYC || CONV_WAIT > 60000) begin : g_bad_wait
      $error("CONV_WAIT must exceed the conversion time");
    end
  endgenerate

  // SDO comes from the other party: two flip-flops first
  logic sdoSync1;
  logic sdoSync2;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdoSync1 <= 1'h0;
      sdoSync2 <= 1'h0;
    end else begin
      sdoSync1 <= link.sdo;
      sdoSync2 <= sdoSync1;
    end
  end

  sarrd_pkg::sarrd_host_state_t state;
  logic [CNT_W-1:0]             cnt;
  logic [BIT_W-1:0]             bitCnt;
  logic [RES-1:0]               shiftIn;
  logic                         doRecal;
  logic                         csPin;
  logic                         sclkPin;
  logic                         sdiPin;

  assign link.convStartSelect = csPin;
  assign link.sclk            = sclkPin;
  assign link.sdi             = sdiPin;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdiPin <= 1'h0;
    end else begin
      sdiPin <= 1'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= sarrd_pkg::H_WAITCAL;
      cnt         <= '0;
      bitCnt      <= '0;
      shiftIn     <= '0;
      doRecal     <= 1'h0;
      csPin       <= 1'h0;
      sclkPin     <= 1'h0;
      ready       <= 1'h0;
      sampleData  <= '0;
      sampleValid <= 1'h0;
      calDone     <= 1'h0;
    end else begin
      sampleValid <= 1'h0;
      calDone     <= 1'h0;
      cnt         <= cnt + 1'h1;
      case (state)
        sarrd_pkg::H_IDLE: begin
          cnt <= '0;
          if (recalReq || sampleReq) begin
            // A recalibration rides on a fresh frame so its count starts clean
            csPin   <= 1'h1;
            doRecal <= recalReq;
            ready   <= 1'h0;
            state   <= sarrd_pkg::H_CONV;
          end
        end
        sarrd_pkg::H_CONV: begin
          if (cnt == CONV_END) begin
            csPin <= 1'h0;
            cnt   <= '0;
            state <= sarrd_pkg::H_EN;
          end
        end
        sarrd_pkg::H_EN: begin
          if (cnt == EN_END) begin
            cnt     <= '0;
            bitCnt  <= '0;
            sclkPin <= 1'h1;
            state   <= doRecal ? sarrd_pkg::H_RECAL : sarrd_pkg::H_SHIFT;
          end
        end
        sarrd_pkg::H_SHIFT, sarrd_pkg::H_RECAL: begin
          if (cnt == HALF_END) begin
            cnt <= '0;
            if (sclkPin) begin
              // Sample just before the falling edge that moves SDO on
              shiftIn <= {shiftIn[RES-2:0], sdoSync2};
              sclkPin <= 1'h0;
              bitCnt  <= bitCnt + 1'h1;
            end else if (state == sarrd_pkg::H_SHIFT && bitCnt == DATA_BITS) begin
              sampleData <= shiftIn;
              state      <= sarrd_pkg::H_QUIET;
            end else if (state == sarrd_pkg::H_RECAL && bitCnt == CAL_BITS) begin
              state <= sarrd_pkg::H_WAITCAL;
            end else begin
              sclkPin <= 1'h1;
            end
          end
        end
        sarrd_pkg::H_QUIET: begin
          if (cnt == QUIET_END) begin
            sampleValid <= 1'h1;
            ready       <= 1'h1;
            state       <= sarrd_pkg::H_IDLE;
          end
        end
        sarrd_pkg::H_WAITCAL: begin
          // Converter holds SDO low while it calibrates; the pull-up ends it
          if (cnt >= POLL_END) begin
            cnt <= POLL_END;
            if (sdoSync2) begin
              calDone <= 1'h1;
              ready   <= 1'h1;
              state   <= sarrd_pkg::H_IDLE;
            end
          end
        end
        default: begin
          state <= sarrd_pkg::H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### sarrd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sarrd_asserts #(
  parameter int RES     = sarrd_pkg::RES_DEFAULT,
  parameter int CAL_CYC = sarrd_pkg::CAL_CYC_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Link signals
  input wire logic convStartSelect,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic sdo
);
  logic        prevSclk;
  logic        inFrame;
  logic [10:0] fallCnt;
  logic [10:0] riseCnt;
  logic        calArm;
  int unsigned rstCyc;
  int unsigned lowCnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) prevSclk <= 1'h0;
    else prevSclk <= sclk;
  end

  // Frame counters restart whenever select is high, as the link does
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      inFrame <= 1'h0;
      fallCnt <= 11'h000;
      riseCnt <= 11'h000;
    end else if (convStartSelect) begin
      inFrame <= 1'h0;
      fallCnt <= 11'h000;
      riseCnt <= 11'h000;
    end else begin
      if ($fell(convStartSelect)) inFrame <= 1'h1;
      if (prevSclk && !sclk && fallCnt != 11'h7FF) fallCnt <= fallCnt + 11'h001;
      if (!prevSclk && sclk && riseCnt != 11'h7FF) riseCnt <= riseCnt + 11'h001;
    end
  end

  // Armed only by the 1024th rise of a frame, so later rises in that frame cannot re-arm it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) calArm <= 1'h0;
    else if (!prevSclk && sclk && !convStartSelect && riseCnt == 11'h3FF) calArm <= 1'h1;
    else if ($rose(sdo)) calArm <= 1'h0;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) rstCyc <= 32'h0000_0000;
    else if (rstCyc != 32'hFFFF_FFFF) rstCyc <= rstCyc + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) lowCnt <= 32'h0000_0000;
    else if (sdo) lowCnt <= 32'h0000_0000;
    else lowCnt <= lowCnt + 32'h0000_0001;
  end

  a_data_needs_select: assert property ((sdoOe && sdoOut) |-> !convStartSelect)
    else $error("data driven on SDO while select high");
  a_result_on_select: assert property ($fell(convStartSelect) |-> sdoOe)
    else $error("no result on SDO when select fell");
  a_quiet_before_start: assert property ($rose(convStartSelect) |-> !sclk && !$past(sclk))
    else $error("serial clock active next to start edge");
  a_sclk_in_frame: assert property ($changed(sclk) |-> !convStartSelect)
    else $error("serial clock moved while select high");
  a_sdo_on_fall: assert property ((inFrame && !convStartSelect && fallCnt < RES
      && !($past(sclk) && !sclk)) |-> $stable(sdo))
    else $error("SDO changed away from a falling clock edge");
  a_release_after_last: assert property ((inFrame && fallCnt >= RES && riseCnt < 11'h400)
      |-> !sdoOe)
    else $error("SDO still driven after the last bit");
  a_powerup_cal_low: assert property ((rstCyc < CAL_CYC - 1) |-> (sdoOe && !sdoOut))
    else $error("SDO not held low in power-up calibration");
  a_powerup_cal_end: assert property ((rstCyc == CAL_CYC + 8) |-> sdo)
    else $error("power-up calibration did not end in time");
  a_recal_low: assert property ($rose(calArm) |-> ##[0:6] (sdoOe && !sdoOut))
    else $error("recalibrate count did not pull SDO low");
  a_cal_length: assert property ((calArm && $rose(sdo)) |-> lowCnt >= CAL_CYC - 4)
    else $error("recalibration ended early");
  a_cal_bounded: assert property (calArm |-> lowCnt <= CAL_CYC + 8)
    else $error("recalibration ran too long");
  a_sdi_held_high: assert property ((rstCyc > 0) |-> sdi)
    else $error("SDI not held high");
endmodule
`default_nettype wire

// ### tb_sar_adc_convert_readout_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_convert_readout_port;
  localparam int CAL = 200;
  // Request to hand-over: conversion wait, enable delay, 16 bit periods, quiet time, hand-over
  localparam int FRAME = sarrd_pkg::CONV_MAX_CYC + sarrd_pkg::EN_CYC + 2 * sarrd_pkg::SCLK_HALF_DEFAULT * 16 + 5;
  // Analog value beside the code it must give; overrange rows saturate
  localparam logic [33:0] ROWS [13] = '{
    {18'h0_0000, 16'h0000}, {18'h0_0001, 16'h0001}, {18'h0_0002, 16'h0002},
    {18'h3_FFFF, 16'hFFFF}, {18'h3_FFFE, 16'hFFFE}, {18'h0_7FFF, 16'h7FFF},
    {18'h0_8000, 16'h7FFF}, {18'h1_FFFF, 16'h7FFF}, {18'h3_8000, 16'h8000},
    {18'h3_7FFF, 16'h8000}, {18'h2_0000, 16'h8000}, {18'h0_5555, 16'h5555},
    {18'h3_AAAA, 16'hAAAA}};

  logic               ref_clk     = 1'h0;
  logic               arst_n      = 1'h0;
  logic               sampleReq   = 1'h0;
  logic               recalReq    = 1'h0;
  logic signed [17:0] analogIn    = 18'h0_0000;
  logic [15:0]        sampleData;
  logic               ready;
  logic               sampleValid;
  logic               calDone;
  logic               tracking;
  logic               converting;
  logic               calibrating;
  int                 err_count    = 0;
  int                 total_checks = 0;
  int                 cycles       = 0;

  sarrd_link_if link();

  sarrd_host #(.RES(16)) u_sarrd_host (
    .ref_clk(ref_clk), .arst_n(arst_n), .link(link), .sampleReq(sampleReq), .recalReq(recalReq),
    .ready(ready), .sampleData(sampleData), .sampleValid(sampleValid), .calDone(calDone));

  sarrd_device #(.RES(16), .CONV_CYC(68), .CAL_CYC(CAL)) u_sarrd_device (
    .ref_clk(ref_clk), .arst_n(arst_n), .link(link), .analogIn(analogIn),
    .tracking(tracking), .converting(converting), .calibrating(calibrating));

  sarrd_asserts #(.RES(16), .CAL_CYC(CAL)) u_sarrd_asserts (
    .ref_clk(ref_clk), .arst_n(arst_n), .convStartSelect(link.convStartSelect), .sclk(link.sclk),
    .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOe(link.sdoOe), .sdo(link.sdo));

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs under 30000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      report_and_stop;
    end
  end

  task automatic wait_cal(input string name);
    int   n;
    int   calCyc;
    logic sdoBad;
    calCyc = 0;
    sdoBad = 1'h0;
    for (n = 0; n < 30000 && calDone !== 1'h1; n++) begin
      @(negedge ref_clk);
      if (calibrating === 1'h1) begin
        calCyc++;
        if (link.sdo !== 1'h0) sdoBad = 1'h1;
      end
    end
    chk(calDone, 1'h1);
    chk(sdoBad, 1'h0);
    chk(calCyc >= CAL - 2 && calCyc <= CAL + 2, 1'h1);
    @(negedge ref_clk);
    chk({tracking, link.sdo, ready}, 3'h7);
    $display("%s done", name);
  endtask

  task automatic do_reset;
    @(posedge ref_clk) arst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({calibrating, tracking, converting, link.sdo}, 4'h8);
    @(posedge ref_clk) arst_n <= 1'h1;
    wait_cal("reset");
  endtask

  task automatic do_sample(input logic [17:0] ain, input logic [15:0] code);
    logic [15:0] word;
    logic        prevSclk;
    int          bits;
    int          convCyc;
    int          n;
    word = 16'h0000;
    prevSclk = 1'h0;
    bits = 0;
    convCyc = 0;
    @(posedge ref_clk);
    analogIn <= ain;
    sampleReq <= 1'h1;
    @(posedge ref_clk) sampleReq <= 1'h0;
    for (n = 0; n < 3000 && sampleValid !== 1'h1; n++) begin
      @(negedge ref_clk);
      if (converting === 1'h1) begin
        convCyc++;
        if (convCyc == 1) chk(tracking, 1'h0);
      end
      // Bits are taken on the rising serial edge, half a period after they change
      if (link.sclk && !prevSclk && !link.convStartSelect) begin
        if (bits == 0) chk({tracking, converting}, 2'h2);
        word = {word[14:0], link.sdo};
        bits++;
      end
      prevSclk = link.sclk;
    end
    chk(sampleValid, 1'h1);
    chk(n, FRAME);
    chk(sampleData, code);
    chk(word, code);
    chk(bits, 32'h0000_0010);
    chk(convCyc >= 1 && convCyc <= 71, 1'h1);
    $display("sample %h done", code);
  endtask

  initial begin
    do_reset();
    for (int i = 0; i < 13; i++) begin
      do_sample(ROWS[i][33:16], ROWS[i][15:0]);
    end
    // Recalibrate, then a sample must still convert correctly
    @(posedge ref_clk) recalReq <= 1'h1;
    @(posedge ref_clk) recalReq <= 1'h0;
    wait_cal("recalibrate");
    do_sample(18'h3_FFFF, 16'hFFFF);
    // Reset in mid-conversion must restart with a calibration
    @(posedge ref_clk) sampleReq <= 1'h1;
    @(posedge ref_clk) sampleReq <= 1'h0;
    repeat (30) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(converting, 1'h1);
    do_reset();
    do_sample(18'h0_0001, 16'h0001);
    report_and_stop;
  end
endmodule
`default_nettype wire
